/* File: rtl/rcg_pkg.sv */
// Package holding offsets, field positions and reset values of the bank.
`default_nettype none
package rcg_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] RCG_IDX_RESPIRATION_CONFIG_TWO  = 8'h0A; // Register index.
  localparam logic [7:0] RCG_IDX_PINS   = 8'h0B; // Register index.
  localparam logic [9:0] RCG_ADDR_RESPIRATION_CONFIG_TWO = {RCG_IDX_RESPIRATION_CONFIG_TWO, 2'b00};
  localparam logic [9:0] RCG_ADDR_PINS  = {RCG_IDX_PINS, 2'b00};
  localparam logic [9:0] RCG_ADDR_MODE  = 10'h040; // Breath mode control.
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RCG_CAL_BIT  = 7;
  localparam int RCG_FREQ_BIT = 2;
  localparam int RCG_REF_BIT  = 1;
  localparam int RCG_ONE_BIT  = 0;
  localparam int RCG_DIR_LSB  = 2;
  localparam int RCG_DAT_LSB  = 0;
  localparam int RCG_NPINS    = 2;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RCG_RESPIRATION_CONFIG_TWO_RST = 8'h03;
  localparam logic [1:0] RCG_DIR_RST   = 2'h3;
  localparam logic [1:0] RCG_DAT_RST   = 2'h0;
  localparam logic [1:0] RCG_MODE_RST  = 2'h0;
endpackage : rcg_pkg
`default_nettype wire

/* File: rtl/rcg_regs.sv */
// Respiration configuration and general-purpose pin register bank on APB.
`default_nettype none
// Summary of operation
// [RQ1] Bit 7 enables offset calibration, default off.
// [RQ2] Bit 2 picks 32 or 64 kHz. The code forces the select off while breath mode bit 0 is set.
// [RQ3] Variants without respiration: software writes one.
// [RQ4] Bit 1 selects internal or external reference.
// [RQ5] Direction bits: zero output, one input.
// [RQ6] Pin data reads return live pin levels.
// [RQ7] Data write sets level of output pins.
// [RQ8] Data write leaves input pins unaffected.
// [RQ9] Some breath modes take the pins away.
// [RQ10] Software writes fixed values in fixed bits.
module rcg_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [1:0]  pin_in,
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe,
  output logic             offset_cal_enable,
  output logic             modulation_freq_select,
  output logic             drive_ref_internal_select,
  output logic             breath_mode_select,
  output logic             pins_taken
);
  import rcg_pkg::*;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic       setup;
  logic       hit_respiration_config_two;
  logic       hit_pins;
  logic       hit_mode;
  logic       mapped;
  logic [7:0] respiration_config_two_q;
  logic [1:0] dir_q;
  logic [1:0] dat_q;
  logic [1:0] mode_q;

  // A setup cycle is answered in the following access cycle.
  assign setup = psel && !penable;
  always_comb begin
    hit_respiration_config_two = 1'b0;
    hit_pins  = 1'b0;
    hit_mode  = 1'b0;
    if (paddr[11:10] != 2'b00) begin
      hit_respiration_config_two = 1'b0;
    end else if (paddr[9:0] == RCG_ADDR_RESPIRATION_CONFIG_TWO) begin
      hit_respiration_config_two = 1'b1;
    end else if (paddr[9:0] == RCG_ADDR_PINS) begin
      hit_pins = 1'b1;
    end else if (paddr[9:0] == RCG_ADDR_MODE) begin
      hit_mode = 1'b1;
    end
    mapped = hit_respiration_config_two | hit_pins | hit_mode;
  end

  // ----------------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------------
  // Pready rises for exactly the access cycle of each transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= 32'h0000_0000;
      if (setup && !pwrite) begin
        if (hit_respiration_config_two) begin
          prdata <= {24'h00_0000, respiration_config_two_q};
        end else if (hit_pins) begin
          prdata <= {28'h000_0000, dir_q, pin_in}; // [RQ6]
        end else if (hit_mode) begin
          prdata <= {30'h0000_0000, mode_q};
        end
      end
    end
  end

  logic wr;
  assign wr = psel && penable && pwrite && pready;

  // ----------------------------------------------------------------------
  // Respiration configuration register
  // ----------------------------------------------------------------------
  // Fixed bits are stored as written; software keeps them legal.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      respiration_config_two_q <= RCG_RESPIRATION_CONFIG_TWO_RST;
    end else if (wr && hit_respiration_config_two) begin
      respiration_config_two_q <= pwdata[7:0]; // [RQ10] [RQ3]
    end
  end

  // Configuration outputs steering the analog front end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_cal_enable         <= RCG_RESPIRATION_CONFIG_TWO_RST[RCG_CAL_BIT];
      modulation_freq_select    <= RCG_RESPIRATION_CONFIG_TWO_RST[RCG_FREQ_BIT];
      drive_ref_internal_select <= RCG_RESPIRATION_CONFIG_TWO_RST[RCG_REF_BIT];
    end else begin
      offset_cal_enable         <= respiration_config_two_q[RCG_CAL_BIT];  // [RQ1]
      // Frequency select only matters in mode zero; one is forced off.
      modulation_freq_select    <= respiration_config_two_q[RCG_FREQ_BIT] &
                                   !mode_q[0]; // [RQ2]
      drive_ref_internal_select <= respiration_config_two_q[RCG_REF_BIT];  // [RQ4]
    end
  end

  // ----------------------------------------------------------------------
  // Breath mode register
  // ----------------------------------------------------------------------
  // Bit 0 is the control mode; bit 1 hands the pins to respiration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= RCG_MODE_RST;
    end else if (wr && hit_mode) begin
      mode_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breath_mode_select <= 1'b0;
      pins_taken         <= 1'b0;
    end else begin
      breath_mode_select <= mode_q[0];
      pins_taken         <= mode_q[1]; // [RQ9]
    end
  end

  // ----------------------------------------------------------------------
  // General-purpose pin register
  // ----------------------------------------------------------------------
  // Direction and data bits; data writes land only on output pins.
  generate
    for (genvar i = 0; i < RCG_NPINS; i++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dir_q[i] <= RCG_DIR_RST[i];
          dat_q[i] <= RCG_DAT_RST[i];
        end else if (wr && hit_pins) begin
          dir_q[i] <= pwdata[RCG_DIR_LSB + i]; // [RQ5] [RQ10]
          if (!dir_q[i]) begin
            dat_q[i] <= pwdata[RCG_DAT_LSB + i]; // [RQ7]
          end
        end
      end
      // Drive the pin only as an output and while the pins are ours.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_oe[i]  <= 1'b0;
          pin_out[i] <= 1'b0;
        end else begin
          pin_oe[i]  <= !dir_q[i] && !mode_q[1]; // [RQ5] [RQ8] [RQ9]
          pin_out[i] <= dat_q[i]; // [RQ7]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_cal;
    @(posedge pclk) disable iff (!presetn)
      ##1 offset_cal_enable == $past(respiration_config_two_q[RCG_CAL_BIT]);
  endproperty
  a_cal: assert property (p_cal) else $error("cal enable wrong"); // [RQ1]

  property p_freq;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_respiration_config_two && !mode_q[0] && !hit_mode) |->
        ##2 modulation_freq_select == $past(pwdata[RCG_FREQ_BIT], 2);
  endproperty
  a_freq: assert property (p_freq) else $error("freq select wrong"); // [RQ2]

  property p_ref;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_respiration_config_two) |->
        ##2 drive_ref_internal_select == $past(pwdata[RCG_REF_BIT], 2);
  endproperty
  a_ref: assert property (p_ref) else $error("ref select wrong"); // [RQ4]

  property p_dir;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_pins && pwdata[RCG_DIR_LSB] && !hit_mode) |->
        ##2 !pin_oe[0];
  endproperty
  a_dir: assert property (p_dir) else $error("input pin driven"); // [RQ5]

  property p_rd;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_pins) |=> prdata[1:0] == $past(pin_in);
  endproperty
  a_rd: assert property (p_rd) else $error("pin readback wrong"); // [RQ6]

  sequence s_out_wr;
    wr && hit_pins && !dir_q[0];
  endsequence
  property p_out;
    @(posedge pclk) disable iff (!presetn)
      s_out_wr |-> ##2 pin_out[0] == $past(pwdata[RCG_DAT_LSB], 2);
  endproperty
  a_out: assert property (p_out) else $error("output level wrong"); // [RQ7]

  property p_in;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_pins && dir_q[0]) |=> $stable(dat_q[0]);
  endproperty
  a_in: assert property (p_in) else $error("input data changed"); // [RQ8]

  property p_taken;
    @(posedge pclk) disable iff (!presetn)
      pins_taken |-> pin_oe == 2'b00;
  endproperty
  a_taken: assert property (p_taken) else $error("pins not released"); // [RQ9]
endmodule : rcg_regs
`default_nettype wire

/* File: dv/rcg_pin_partner.sv */
// Model of the circuitry outside the two general-purpose pins.
`default_nettype none
module rcg_pin_partner (
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] ext_level,
  output logic      [1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pin shows the device level while driven, else the outside level.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule : rcg_pin_partner
`default_nettype wire

/* File: dv/resp_cfg_and_io_pin_regs_tb_top.sv */
// Self-checking bench of the configuration and pin register bank.
`default_nettype none
module resp_cfg_and_io_pin_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rcg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0]  pin_in, pin_out, pin_oe, ext_level;
  logic        offset_cal_enable, modulation_freq_select;
  logic        drive_ref_internal_select, breath_mode_select, pins_taken;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  rcg_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .pin_in, .pin_out, .pin_oe,
    .offset_cal_enable, .modulation_freq_select,
    .drive_ref_internal_select, .breath_mode_select, .pins_taken);
  rcg_pin_partner ext (.pin_out, .pin_oe, .ext_level, .pin_in);
  // Free-running clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Checked %0d, failed %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One APB transfer, then two idle edges so derived outputs settle.
  // The wait for pready is open ended; only the cycle ceiling ends it.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rdat);
  endtask : rd
  // Main sequence.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_level = 2'h2;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("cal", 0, offset_cal_enable);
    chk("freq", 0, modulation_freq_select);
    chk("ref", 1, drive_ref_internal_select);
    chk("oe", 0, pin_oe);
    rd(RCG_ADDR_RESPIRATION_CONFIG_TWO, 32'h03, "respiration_config_two");
    rd(RCG_ADDR_PINS, 32'h0E, "pins");
    $display("Test reset done");
    apb(1'b1, RCG_ADDR_RESPIRATION_CONFIG_TWO, 32'h87);
    chk("slverr", 0, rerr);
    chk("cal", 1, offset_cal_enable);
    chk("freq", 1, modulation_freq_select);
    apb(1'b1, RCG_ADDR_RESPIRATION_CONFIG_TWO, 32'h05);
    chk("cal", 0, offset_cal_enable);
    chk("ref", 0, drive_ref_internal_select);
    rd(RCG_ADDR_RESPIRATION_CONFIG_TWO, 32'h05, "respiration_config_two");
    apb(1'b1, RCG_ADDR_MODE, 32'h01);
    chk("freq", 0, modulation_freq_select);
    chk("mode", 1, breath_mode_select);
    apb(1'b1, RCG_ADDR_MODE, 32'h00);
    chk("freq", 1, modulation_freq_select);
    $display("Test config done");
    apb(1'b1, RCG_ADDR_PINS, 32'h0F);
    chk("oe", 0, pin_oe);
    apb(1'b1, RCG_ADDR_PINS, 32'h00);
    chk("oe", 3, pin_oe);
    chk("out", 0, pin_out);
    apb(1'b1, RCG_ADDR_PINS, 32'h01);
    chk("out", 1, pin_out);
    rd(RCG_ADDR_PINS, 32'h01, "pins");
    apb(1'b1, RCG_ADDR_PINS, 32'h08);
    apb(1'b1, RCG_ADDR_PINS, 32'h0B);
    chk("oe", 1, pin_oe);
    chk("out", 1, pin_out);
    rd(RCG_ADDR_PINS, 32'h0B, "pins");
    apb(1'b1, RCG_ADDR_MODE, 32'h02);
    chk("taken", 1, pins_taken);
    chk("oe", 0, pin_oe);
    apb(1'b1, RCG_ADDR_MODE, 32'h00);
    chk("taken", 0, pins_taken);
    $display("Test pins done");
    rd(12'h030, 32'h0, "unmapped");
    chk("slverr", 1, rerr);
    $display("Test unmapped done");
    close_out();
  end
endmodule : resp_cfg_and_io_pin_regs_tb_top
`default_nettype wire
